// file: parp_mmu.sv
`timescale 1ns/100ps
// Operation
// - status mode bits pick one of three sets
// - pure-code references use instruction registers
// - top three address bits index page
// - base register holds twelve bits only
// - base plus block, low six pass
// - processor address treated as virtual
// - pages start on 8192-word virtual boundaries
// - pages map independently, shared bases allowed
// - key check aborts via vector 250
// - key zero aborts every access
// - key two aborts writes only
// - key six allows everything
// - split spaces only when control enables
// - user-user previous read uses data space
// - mode code ten aborts everything
// - abort vector pc 250, status 252
module parp_mmu #(
	parameter int NREG = 48
) (
	// clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	// control
	input  wire logic        i_mmu_enable,
	input  wire logic        i_split_enable,
	// processor reference
	input  wire logic        i_req,
	input  wire logic [15:0] i_virtual_address,
	input  wire logic [15:0] i_processor_status_word,
	input  wire logic        i_write,
	input  wire logic        i_pure_code,
	input  wire logic        i_prev_ispace_read,
	// register loading
	input  wire logic        i_cfg_we,
	input  wire logic [5:0]  i_cfg_idx,
	input  wire logic [11:0] i_cfg_base,
	input  wire logic [2:0]  i_cfg_key,
	input  wire logic        i_cfg_rd,
	// memory side
	output logic             o_mem_start,
	output logic [17:0]      o_mem_addr,
	output logic             o_mem_write,
	// abort side
	output logic             o_abort,
	output logic [1:0]       o_abort_cause,
	output logic [15:0]      o_abort_vec_pc,
	output logic [15:0]      o_abort_vec_status,
	// register readback
	output logic [11:0]      o_cfg_base,
	output logic [2:0]       o_cfg_key
);
	// =====================================================
	// register store
	// twelve-bit base only
	logic [11:0] page_base_register [NREG];
	logic [2:0]  page_descriptor_register [NREG];
	logic        cfg_idx_ok;
	logic        cfg_write;

	// indices past the last entry are dropped, never wrapped
	assign cfg_idx_ok = (i_cfg_idx < 6'(NREG));
	assign cfg_write  = i_cfg_we && cfg_idx_ok;

	// not cleared by reset: software loads them before enabling
	always_ff @(posedge i_core_clk) begin
		if (cfg_write) begin
			page_base_register[i_cfg_idx]       <= i_cfg_base;
			page_descriptor_register[i_cfg_idx] <= i_cfg_key;
		end
	end

	// =====================================================
	// mode decode
	logic [1:0]  cur_mode;
	logic [1:0]  prev_mode;
	logic        cur_kernel;
	logic        cur_super;
	logic        cur_user;
	logic        prev_user;
	logic        user_user;
	logic [1:0]  set_sel;

	assign cur_mode   = i_processor_status_word[parp_pkg::MODE_HI:
		parp_pkg::MODE_LO];
	// previous mode sits just below current mode
	assign prev_mode  = i_processor_status_word[parp_pkg::PREV_HI:
		parp_pkg::PREV_LO];
	// only three codes name a set
	assign cur_kernel = (cur_mode == parp_pkg::MODE_KERNEL);
	assign cur_super  = (cur_mode == parp_pkg::MODE_SUPER);
	assign cur_user   = (cur_mode == parp_pkg::MODE_USER);
	assign prev_user  = (prev_mode == parp_pkg::MODE_USER);
	assign user_user  = cur_user && prev_user;
	// illegal code lands on the kernel set; it aborts anyway
	assign set_sel    = cur_user ? parp_pkg::SET_USER :
		cur_super ? parp_pkg::SET_SUPER : parp_pkg::SET_KERNEL;

	// =====================================================
	// reference kind
	logic        ref_read;
	logic        ref_write;

	assign ref_write = i_write;
	// fetches count as reads for the key check
	assign ref_read  = !i_write;

	// =====================================================
	// space and page selection
	logic [2:0]  page_idx;
	logic        prev_demote;
	logic        pure_ref;
	logic        use_i;
	logic        use_d;
	logic [5:0]  reg_idx;
	logic [11:0] sel_base;
	logic [2:0]  sel_key;

	// each page owns an 8192-word virtual slot
	assign page_idx    = i_virtual_address[parp_pkg::PAGE_HI:
		parp_pkg::PAGE_LO];
	// user-user previous fetch demoted to data
	assign prev_demote = i_prev_ispace_read && user_user;
	assign pure_ref    = i_pure_code && !prev_demote;
	// split off: everything maps instruction half
	assign use_i       = !i_split_enable || pure_ref;
	assign use_d       = !use_i;
	// layout: set*16 + (data?8:0) + page
	assign reg_idx     = {set_sel, use_d, page_idx};
	assign sel_base    = page_base_register[reg_idx];
	assign sel_key     = page_descriptor_register[reg_idx];

	// =====================================================
	// address formation
	logic [17:0] reloc_addr;
	logic [17:0] flat_addr;
	logic [17:0] mem_addr_d;

	// no cross-page interaction, shared bases fine
	parp_relocate u_reloc (
		.i_base  (sel_base),
		.i_vaddr (i_virtual_address),
		.o_paddr (reloc_addr)
	);

	assign flat_addr  = {2'h0, i_virtual_address};
	// processor address always virtual when enabled
	assign mem_addr_d = i_mmu_enable ? reloc_addr : flat_addr;

	// =====================================================
	// access check
	logic        key_nonres;
	logic        key_rdonly;
	logic        key_full;
	logic        key_other;
	logic        bad_mode;
	logic        key_ok;
	logic        deny;
	logic        cause_nonres;
	logic        cause_rdonly;
	parp_pkg::parp_cause_t cause;

	assign key_nonres   = (sel_key == parp_pkg::KEY_NONRES);
	assign key_rdonly   = (sel_key == parp_pkg::KEY_RDONLY);
	assign key_full     = (sel_key == parp_pkg::KEY_FULL);
	// statistics keys are not built; they refuse like key zero
	assign key_other    = !(key_nonres || key_rdonly || key_full);
	assign bad_mode     = !(cur_kernel || cur_super || cur_user);
	assign key_ok       = key_full || (key_rdonly && ref_read);
	assign deny         = i_mmu_enable && (bad_mode || !key_ok);
	assign cause_nonres = key_nonres || key_other;
	assign cause_rdonly = key_rdonly && ref_write;
	assign cause        = !deny ? parp_pkg::PARP_OK :
		bad_mode ? parp_pkg::PARP_BADMODE :
		cause_rdonly ? parp_pkg::PARP_RDONLY :
		cause_nonres ? parp_pkg::PARP_NONRES : parp_pkg::PARP_OK;

	// =====================================================
	// reference next values
	logic        mem_start_d;
	logic        mem_write_d;
	logic        abort_d;
	logic [1:0]  cause_d;

	// memory start suppressed in same cycle as abort
	assign mem_start_d = i_req && !deny;
	assign mem_write_d = mem_start_d && ref_write;
	assign abort_d     = i_req && deny;
	assign cause_d     = abort_d ? cause : parp_pkg::PARP_OK;

	// =====================================================
	// memory side registers
	// start pulse one cycle after the request
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_mem_start <= 1'b0;
		end else begin
			o_mem_start <= mem_start_d;
		end
	end

	// write qualifier only rides with a started cycle
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_mem_write <= 1'b0;
		end else begin
			o_mem_write <= mem_write_d;
		end
	end

	// address refreshed every cycle, valid with start
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_mem_addr <= 18'h0;
		end else begin
			o_mem_addr <= mem_addr_d;
		end
	end

	// =====================================================
	// abort side registers
	// abort pulse replaces the memory start
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_abort <= 1'b0;
		end else begin
			o_abort <= abort_d;
		end
	end

	// cause reads zero whenever no abort stands
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_abort_cause <= 2'h0;
		end else begin
			o_abort_cause <= cause_d;
		end
	end

	// =====================================================
	// vector registers
	// vector pair fixed
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_abort_vec_pc <= parp_pkg::VEC_PC;
		end else begin
			o_abort_vec_pc <= parp_pkg::VEC_PC;
		end
	end

	// status slot follows the pc slot
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_abort_vec_status <= parp_pkg::VEC_STATUS;
		end else begin
			o_abort_vec_status <= parp_pkg::VEC_STATUS;
		end
	end

	// =====================================================
	// register readback
	logic [11:0] rd_base;
	logic [2:0]  rd_key;

	// out-of-range index reads zero; live entries x until written
	assign rd_base = cfg_idx_ok ? page_base_register[i_cfg_idx] :
		12'h0;
	assign rd_key  = cfg_idx_ok ? page_descriptor_register[i_cfg_idx] :
		3'h0;

	// =====================================================
	// readback registers
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_cfg_base <= 12'h0;
		end else if (i_cfg_rd) begin
			o_cfg_base <= rd_base;
		end
	end

	// key latched on the same strobe
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_cfg_key <= 3'h0;
		end else if (i_cfg_rd) begin
			o_cfg_key <= rd_key;
		end
	end
endmodule

// file: parp_pkg.sv
package parp_pkg;
	// =====================================================
	// address geometry
	localparam int VA_W       = 16;
	localparam int PA_W       = 18;
	localparam int BASE_W     = 12;
	localparam int BLK_W      = 7;
	localparam int OFS_W      = 6;
	localparam int PAGE_LO    = 13;
	localparam int PAGE_HI    = 15;
	localparam int BLK_LO     = 6;
	localparam int BLK_HI     = 12;
	localparam int KEY_W      = 3;
	localparam int MODE_W     = 2;
	localparam int MODE_LO    = 14;
	localparam int MODE_HI    = 15;
	localparam int PREV_LO    = 12;
	localparam int PREV_HI    = 13;
	localparam int PAGES      = 8;
	localparam int SETS       = 3;
	localparam int REGS       = 48;
	localparam int IDX_W      = 6;
	// =====================================================
	// mode codes
	localparam logic [1:0] MODE_KERNEL  = 2'h0;
	localparam logic [1:0] MODE_SUPER   = 2'h1;
	localparam logic [1:0] MODE_ILLEGAL = 2'h2;
	localparam logic [1:0] MODE_USER    = 2'h3;
	// =====================================================
	// register set codes
	localparam logic [1:0] SET_KERNEL   = 2'h0;
	localparam logic [1:0] SET_SUPER    = 2'h1;
	localparam logic [1:0] SET_USER     = 2'h2;
	// =====================================================
	// access keys
	localparam logic [2:0] KEY_NONRES   = 3'h0;
	localparam logic [2:0] KEY_RDONLY   = 3'h2;
	localparam logic [2:0] KEY_FULL     = 3'h6;
	// =====================================================
	// abort vector, kernel data space
	localparam logic [15:0] VEC_PC      = 16'h00a8;
	localparam logic [15:0] VEC_STATUS  = 16'h00aa;
	// =====================================================
	// abort causes
	typedef enum logic [1:0] {
		PARP_OK,
		PARP_NONRES,
		PARP_RDONLY,
		PARP_BADMODE
	} parp_cause_t;
endpackage

// file: parp_relocate.sv
`timescale 1ns/100ps
// combinational base add: one adder, shared by all registers
module parp_relocate (
	// inputs
	input  wire logic [11:0] i_base,
	input  wire logic [15:0] i_vaddr,
	// outputs
	output logic      [17:0] o_paddr
);
	logic [11:0] blk_ext;
	logic [11:0] hi_sum;

	assign blk_ext = {{(parp_pkg::BASE_W - parp_pkg::BLK_W){1'b0}},
		i_vaddr[parp_pkg::BLK_HI:parp_pkg::BLK_LO]};
	assign hi_sum  = i_base + blk_ext;
	assign o_paddr = {hi_sum, i_vaddr[parp_pkg::OFS_W-1:0]};
endmodule

// file: parp_mmu_chk.sv
`timescale 1ns/100ps
// ==========
// port checks
module parp_mmu_chk (
	// clock, reset, control
	input wire logic        i_core_clk,
	input wire logic        i_rst,
	input wire logic        i_mmu_enable,
	// reference
	input wire logic        i_req,
	input wire logic        i_write,
	input wire logic [15:0] i_virtual_address,
	input wire logic [15:0] i_processor_status_word,
	// answer
	input wire logic        o_mem_start,
	input wire logic        o_mem_write,
	input wire logic        o_abort,
	input wire logic [1:0]  o_abort_cause,
	input wire logic [17:0] o_mem_addr,
	input wire logic [15:0] o_abort_vec_pc
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	chk_one_answer:
		assert property (i_req |=> o_mem_start != o_abort)
		else $error("reference without exactly one answer");
	chk_quiet_idle:
		assert property (!i_req |=> !o_mem_start && !o_abort)
		else $error("answer without reference");
	chk_pass_through:
		assert property (i_req && !i_mmu_enable |=> o_mem_start
			&& o_mem_addr == {2'h0, $past(i_virtual_address)})
		else $error("disabled reference not passed through");
	chk_bad_mode:
		assert property (i_req && i_mmu_enable
			&& i_processor_status_word[15:14] == 2'h2
			|=> o_abort && o_abort_cause == 2'h3)
		else $error("illegal mode not aborted");
	chk_low_bits:
		assert property (i_req |=> o_abort
			|| o_mem_addr[5:0] == $past(i_virtual_address[5:0]))
		else $error("offset bits changed");
	chk_rdonly_write:
		assert property (o_abort && o_abort_cause == 2'h2 |-> $past(i_write))
		else $error("read-only cause without write");
	chk_write_qual:
		assert property (o_mem_write |-> o_mem_start && $past(i_write))
		else $error("write qualifier without write cycle");
	chk_vec_fixed:
		assert property (o_abort |-> o_abort_vec_pc == parp_pkg::VEC_PC)
		else $error("abort vector wrong");
endmodule
bind parp_mmu parp_mmu_chk u_chk (.i_core_clk, .i_rst, .i_mmu_enable,
	.i_req, .i_write, .i_virtual_address, .i_processor_status_word,
	.o_mem_start, .o_mem_write, .o_abort, .o_abort_cause, .o_mem_addr,
	.o_abort_vec_pc);

// file: parp_core_model.sv
`timescale 1ns/100ps
// ==========
// processor core issuing references
module parp_core_model (
	// clock and answer
	input  wire logic        i_core_clk,
	input  wire logic        i_abort,
	input  wire logic [1:0]  i_cause,
	input  wire logic [17:0] i_addr,
	// reference, kind = write, pure code, previous read
	output logic             o_req,
	output logic [15:0]      o_vaddr,
	output logic [15:0]      o_psw,
	output logic [2:0]       o_kind
);
	initial {o_req, o_vaddr, o_psw, o_kind} = '0;
	task automatic access(input logic [15:0] vaddr, psw,
		input logic [2:0] k, output logic [19:0] r);
		@(negedge i_core_clk);
		{o_req, o_vaddr, o_psw, o_kind} = {1'b1, vaddr, psw, k};
		@(negedge i_core_clk);
		r = i_abort ? {2'h1, 16'h0, i_cause} : {2'h0, i_addr};
		// released bus shows no stale address
		{o_req, o_vaddr} = {1'b0, ~vaddr};
	endtask
endmodule

// file: parp_mmu_tb.sv
`timescale 1ns/100ps
// ==========
// bench
module parp_mmu_tb;
	logic clk = 0, rst = 1, en = 0, sp = 0, we = 0, rd = 0;
	logic [5:0] idx = 0;
	logic [11:0] base = 0;
	logic [2:0] key = 0, kind, ck;
	logic req, start, mwr, abort;
	logic [1:0] cause;
	logic [15:0] vaddr, psw, vpc, vps;
	logic [17:0] addr;
	logic [11:0] cb;
	int failures = 0, n_tests = 0;
	always #2 clk = ~clk;
	parp_core_model u_core (.i_core_clk(clk), .i_abort(abort),
		.i_cause(cause), .i_addr(addr), .o_req(req), .o_vaddr(vaddr),
		.o_psw(psw), .o_kind(kind));
	parp_mmu u_dut (.i_core_clk(clk), .i_rst(rst), .i_mmu_enable(en),
		.i_split_enable(sp), .i_req(req), .i_virtual_address(vaddr),
		.i_processor_status_word(psw), .i_write(kind[2]),
		.i_pure_code(kind[1]), .i_prev_ispace_read(kind[0]),
		.i_cfg_we(we), .i_cfg_idx(idx), .i_cfg_base(base),
		.i_cfg_key(key), .i_cfg_rd(rd), .o_mem_start(start),
		.o_mem_addr(addr), .o_mem_write(mwr), .o_abort(abort),
		.o_abort_cause(cause), .o_abort_vec_pc(vpc),
		.o_abort_vec_status(vps), .o_cfg_base(cb), .o_cfg_key(ck));
	task automatic chk(input logic [19:0] s, e);
		n_tests++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic ld(input logic [5:0] i, input logic [11:0] b,
		input logic [2:0] k);
		@(negedge clk);
		{we, idx, base, key} = {1'b1, i, b, k};
		@(negedge clk);
		we = 0;
	endtask
	task automatic t(input logic [15:0] v, p, input logic [2:0] k,
		input logic [19:0] e);
		logic [19:0] r;
		u_core.access(v, p, k, r);
		chk(r, e);
		chk({18'h0, start, mwr}, {18'h0, !e[18], !e[18] && k[2]});
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#2000;
		failures++;
		tally_and_finish;
	end
	initial begin
		repeat (8) @(negedge clk);
		rst = 0;
		ld(6'd0, 12'h064, 3'h6);
		ld(6'd8, 12'h200, 3'h2);
		ld(6'd4, 12'h010, 3'h6);
		ld(6'd6, 12'h010, 3'h6);
		ld(6'd33, 12'h7ff, 3'h0);
		ld(6'd41, 12'h040, 3'h6);
		ld(6'd23, 12'h000, 3'h3);
		@(negedge clk);
		{rd, idx} = {1'b1, 6'd0};
		@(negedge clk);
		rd = 0;
		chk({5'h0, cb, ck}, 20'h00326);
		t(16'hffff, 16'h8000, 3'h4, 20'h0ffff);
		en = 1;
		t(16'h0042, 16'h0000, 3'h4, 20'h01942);
		sp = 1;
		t(16'h0042, 16'h0000, 3'h2, 20'h01942);
		t(16'h0042, 16'h0000, 3'h0, 20'h08042);
		t(16'h0042, 16'h0000, 3'h4, 20'h40002);
		t(16'h9fc0, 16'h0000, 3'h2, 20'h023c0);
		t(16'hdfc0, 16'h0000, 3'h2, 20'h023c0);
		t(16'h2000, 16'hf000, 3'h2, 20'h40001);
		t(16'h2000, 16'hf000, 3'h3, 20'h01000);
		t(16'he000, 16'h4000, 3'h2, 20'h40001);
		t(16'h0042, 16'h8000, 3'h2, 20'h40003);
		chk({4'h0, vpc}, 20'h000a8);
		chk({4'h0, vps}, 20'h000aa);
		tally_and_finish;
	end
endmodule
